// ### hw/fsol_pkg.sv
// package: offsets, field layouts and constants of the security option loader
package fsol_pkg;
  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [15:0] WORKING_OPTION_OFS = 16'h1821;
  localparam logic [15:0] FLASH_CONFIG_OFS = 16'h1823;
  localparam logic [15:0] WORKING_PROTECTION_OFS = 16'h1824;
  localparam logic [15:0] SECURITY_STATUS_OFS = 16'h1828;
  localparam logic [15:0] KEY_BASE_OFS = 16'hffb0;
  localparam logic [15:0] STORED_PROTECTION_OFS = 16'hffbd;
  localparam logic [15:0] STORED_OPTION_OFS = 16'hffbf;
  // ****************************************************************
  // field positions and values
  // ****************************************************************
  localparam int KEY_ENABLE_POS = 7;
  localparam int VECTOR_REDIRECT_POS = 6;
  localparam int KEY_ACCESS_POS = 5;
  localparam int PROTECT_DISABLE_POS = 0;
  localparam logic [1:0] SECURITY_FIELD_UNSECURED = 2'h2;
  localparam logic [7:0] OPTION_RW_MASK = 8'hc3;
  localparam logic [7:0] CONFIG_RW_MASK = 8'h20;
  localparam int KEY_BYTES = 8;
  localparam logic [7:0] CMD_BLANK_CHECK = 8'h05;
  localparam logic [7:0] CMD_MASS_ERASE = 8'h41;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam int LOAD_WORDS = 10;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } fsol_bus_t;

  typedef struct packed {
    logic [15:0] addr;
    logic rd;
  } fsol_nv_req_t;

  typedef enum {
    LD_IDLE,
    LD_READ,
    LD_DONE
  } fsol_load_state_t;
endpackage

// ### hw/fsol_nv_loader.sv
// reset-time copier of stored option, protection and key bytes
module fsol_nv_loader (
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  output fsol_pkg::fsol_nv_req_t nv_req_o,
  input wire logic [7:0] nv_rdata_i,
  output logic load_busy_o,
  output logic [7:0] prot_o,
  output logic [7:0] opt_o,
  output logic [63:0] key_o
);
  // ****************************************************************
  // sequencer
  // ****************************************************************
  fsol_pkg::fsol_load_state_t state_reg;
  logic [3:0] idx_reg;
  logic [3:0] cap_idx_reg;
  logic cap_reg;
  logic [15:0] addr_sel;

  // index 0..7 key bytes, 8 protection, 9 option
  always_comb begin
    if (idx_reg < 4'(fsol_pkg::KEY_BYTES)) begin
      addr_sel = fsol_pkg::KEY_BASE_OFS + {12'h000, idx_reg};
    end else if (idx_reg == 4'(fsol_pkg::KEY_BYTES)) begin
      addr_sel = fsol_pkg::STORED_PROTECTION_OFS;
    end else begin
      addr_sel = fsol_pkg::STORED_OPTION_OFS;
    end
  end

  assign nv_req_o.addr = addr_sel;
  assign nv_req_o.rd = (state_reg == fsol_pkg::LD_READ);
  // busy covers the last capture, so working regs never take a stale option byte
  assign load_busy_o = (state_reg != fsol_pkg::LD_DONE) || cap_reg;

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      state_reg <= fsol_pkg::LD_IDLE;
      idx_reg <= 4'h0;
    end else begin
      case (state_reg)
        fsol_pkg::LD_IDLE: state_reg <= fsol_pkg::LD_READ;
        fsol_pkg::LD_READ: begin
          if (idx_reg == 4'(fsol_pkg::LOAD_WORDS - 1)) begin
            state_reg <= fsol_pkg::LD_DONE;
          end
          idx_reg <= idx_reg + 4'h1;
        end
        fsol_pkg::LD_DONE: state_reg <= fsol_pkg::LD_DONE;
        default: state_reg <= fsol_pkg::LD_IDLE;
      endcase
    end
  end

  // read data arrive one cycle after the request
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      cap_reg <= 1'b0;
      cap_idx_reg <= 4'h0;
    end else begin
      cap_reg <= nv_req_o.rd;
      cap_idx_reg <= idx_reg;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      prot_o <= fsol_pkg::RESET_BYTE;
      opt_o <= fsol_pkg::RESET_BYTE;
      key_o <= 64'h0000_0000_0000_0000;
    end else if (cap_reg) begin
      if (cap_idx_reg < 4'(fsol_pkg::KEY_BYTES)) begin
        key_o[cap_idx_reg[2:0]*8 +: 8] <= nv_rdata_i;
      end else if (cap_idx_reg == 4'(fsol_pkg::KEY_BYTES)) begin
        prot_o <= nv_rdata_i;
      end else begin
        opt_o <= nv_rdata_i;
      end
    end
  end
endmodule

// ### hw/fsol_key_compare.sv
// collects eight written key bytes and compares them to the stored key
module fsol_key_compare #(
  parameter int N_BYTES = 8
) (
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic arm_i,
  input wire logic byte_we_i,
  input wire logic [2:0] byte_idx_i,
  input wire logic [7:0] byte_i,
  input wire logic [8*N_BYTES-1:0] stored_key_i,
  output logic all_written_o,
  output logic match_o
);
  // ****************************************************************
  // per-byte capture
  // ****************************************************************
  logic [N_BYTES-1:0] seen_reg;
  logic [N_BYTES-1:0] eq_reg;

  for (genvar g = 0; g < N_BYTES; g++) begin : g_byte
    always_ff @(posedge SYS_CLK_I) begin
      if (RST_I || !arm_i) begin
        seen_reg[g] <= 1'b0;
        eq_reg[g] <= 1'b0;
      end else if (byte_we_i && byte_idx_i == 3'(g)) begin
        seen_reg[g] <= 1'b1;
        eq_reg[g] <= (byte_i == stored_key_i[8*g +: 8]);
      end
    end
  end

  assign all_written_o = &seen_reg;
  assign match_o = (&seen_reg) && (&eq_reg);
endmodule

// ### hw/fsol_top.sv
// flash security option loader: working options, key unlock, erase clear
// Contract
// (R1) every reset copies stored protection and option bytes into working registers
// (R2) an eight-byte comparison key lives in the stored register area
// (R3) key may unlock security only while working key enable bit is 1
// (R4) key attempts accepted only from code running in secure memory
// (R5) debug accesses can never present or compare the key
// (R6) stored key enable of 0 disables key unlocking completely
// (R7) with key disabled, only verified mass erase and blank check clears security
// (R8) security field value 1:0 is unsecured, all others secure
// (R9) blank check 0x05 and mass erase 0x41 commands are recognised
// (R10) all eight written bytes must match to unlock until next reset
module fsol_top (
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic [15:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  input wire logic SECURE_CODE_I,
  input wire logic DEBUG_ACCESS_I,
  output logic [15:0] NV_ADDR_O,
  output logic NV_RD_O,
  input wire logic [7:0] NV_RDATA_I,
  input wire logic [7:0] FLASH_CMD_I,
  input wire logic FLASH_CMD_DONE_I,
  input wire logic FLASH_BLANK_I,
  output logic LOAD_BUSY_O,
  output logic SECURE_O,
  output logic KEY_UNLOCKED_O,
  output logic [7:0] PROTECTION_O,
  output logic VECTOR_REDIRECT_DISABLE_O
);
  // ****************************************************************
  // signals
  // ****************************************************************
  fsol_pkg::fsol_bus_t bus;
  fsol_pkg::fsol_nv_req_t nv_req;
  logic load_busy;
  logic [7:0] nv_prot;
  logic [7:0] nv_opt;
  logic [63:0] stored_key;
  logic [7:0] opt_reg;
  logic [7:0] prot_reg;
  logic [7:0] cfg_reg;
  logic load_busy_q_reg;
  logic key_unlocked_reg;
  logic erase_seen_reg;
  logic erase_unlocked_reg;
  logic key_allowed;
  logic key_arm;
  logic key_byte_we;
  logic key_all;
  logic key_match;
  logic in_key_window;
  logic [7:0] rdata_next;

  assign bus.addr = ADDR_I;
  assign bus.wdata = WDATA_I;
  assign bus.wr = WR_I;
  assign bus.rd = RD_I;

  // ****************************************************************
  // reset-time copy of stored bytes
  // ****************************************************************
  fsol_nv_loader u_loader (
    .SYS_CLK_I(SYS_CLK_I),
    .RST_I(RST_I),
    .nv_req_o(nv_req),
    .nv_rdata_i(NV_RDATA_I),
    .load_busy_o(load_busy),
    .prot_o(nv_prot),
    .opt_o(nv_opt),
    .key_o(stored_key)
  );

  assign NV_ADDR_O = nv_req.addr;
  assign NV_RD_O = nv_req.rd;
  assign LOAD_BUSY_O = load_busy;

  // working registers take the stored copies when loading ends
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      load_busy_q_reg <= 1'b1;
    end else begin
      load_busy_q_reg <= load_busy;
    end
  end

  // ****************************************************************
  // working option and protection registers
  // ****************************************************************
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      opt_reg <= fsol_pkg::RESET_BYTE;
    end else if (load_busy_q_reg && !load_busy) begin
      opt_reg <= nv_opt & fsol_pkg::OPTION_RW_MASK; // [R1]
    end
  end

  // software may write any protection value after load, loosening it as well
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      prot_reg <= fsol_pkg::RESET_BYTE;
    end else if (load_busy_q_reg && !load_busy) begin
      prot_reg <= nv_prot; // [R1]
    end else if (bus.wr && bus.addr == fsol_pkg::WORKING_PROTECTION_OFS && !load_busy) begin
      prot_reg <= bus.wdata;
    end
  end

  // ****************************************************************
  // key access control
  // ****************************************************************
  // key path only when enabled, secure code, and not from debug
  assign key_allowed = opt_reg[fsol_pkg::KEY_ENABLE_POS] // [R3] [R6]
                       && SECURE_CODE_I && !DEBUG_ACCESS_I; // [R4] [R5]

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      cfg_reg <= fsol_pkg::RESET_BYTE;
    end else if (bus.wr && bus.addr == fsol_pkg::FLASH_CONFIG_OFS && !load_busy) begin
      cfg_reg <= bus.wdata & fsol_pkg::CONFIG_RW_MASK & {8{key_allowed}}; // [R4]
    end else if (!opt_reg[fsol_pkg::KEY_ENABLE_POS]) begin
      cfg_reg <= fsol_pkg::RESET_BYTE; // [R6]
    end
  end

  assign key_arm = cfg_reg[fsol_pkg::KEY_ACCESS_POS];
  assign in_key_window = (bus.addr[15:3] == fsol_pkg::KEY_BASE_OFS[15:3]);
  // key bytes written into the stored-key window while armed
  assign key_byte_we = bus.wr && in_key_window && key_arm && key_allowed; // [R2] [R5]

  fsol_key_compare #(
    .N_BYTES(fsol_pkg::KEY_BYTES)
  ) u_cmp (
    .SYS_CLK_I(SYS_CLK_I),
    .RST_I(RST_I),
    .arm_i(key_arm),
    .byte_we_i(key_byte_we),
    .byte_idx_i(bus.addr[2:0]),
    .byte_i(bus.wdata),
    .stored_key_i(stored_key),
    .all_written_o(key_all),
    .match_o(key_match)
  );

  // unlock holds until the next reset; wrong key leaves security on
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      key_unlocked_reg <= 1'b0;
    end else if (key_all && key_match && opt_reg[fsol_pkg::KEY_ENABLE_POS]) begin
      key_unlocked_reg <= 1'b1; // [R10] [R3]
    end
  end

  // ****************************************************************
  // mass erase then blank check clears security
  // ****************************************************************
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      erase_seen_reg <= 1'b0;
      erase_unlocked_reg <= 1'b0;
    end else if (FLASH_CMD_DONE_I) begin
      if (FLASH_CMD_I == fsol_pkg::CMD_MASS_ERASE) begin
        erase_seen_reg <= 1'b1; // [R9]
      end else if (FLASH_CMD_I == fsol_pkg::CMD_BLANK_CHECK) begin
        erase_unlocked_reg <= erase_seen_reg && FLASH_BLANK_I; // [R7] [R9]
      end else begin
        erase_seen_reg <= 1'b0;
      end
    end
  end

  // secure while loading, otherwise unless the field reads unsecured, a key match, or verified erase
  assign SECURE_O = load_busy
                    || ((opt_reg[1:0] != fsol_pkg::SECURITY_FIELD_UNSECURED) // [R8]
                        && !key_unlocked_reg && !erase_unlocked_reg); // [R7]
  assign KEY_UNLOCKED_O = key_unlocked_reg;
  assign PROTECTION_O = prot_reg;
  assign VECTOR_REDIRECT_DISABLE_O = opt_reg[fsol_pkg::VECTOR_REDIRECT_POS];

  // ****************************************************************
  // register read port
  // ****************************************************************
  // stored key never reads back, so the compare cannot be bypassed
  always_comb begin
    rdata_next = fsol_pkg::UNMAPPED_READ;
    case (bus.addr)
      fsol_pkg::WORKING_OPTION_OFS: rdata_next = opt_reg;
      fsol_pkg::FLASH_CONFIG_OFS: rdata_next = cfg_reg;
      fsol_pkg::WORKING_PROTECTION_OFS: rdata_next = prot_reg;
      fsol_pkg::STORED_PROTECTION_OFS: rdata_next = nv_prot;
      fsol_pkg::STORED_OPTION_OFS: rdata_next = nv_opt;
      fsol_pkg::SECURITY_STATUS_OFS:
        rdata_next = {5'h00, erase_unlocked_reg, key_unlocked_reg, SECURE_O};
      default: rdata_next = fsol_pkg::UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      RDATA_O <= fsol_pkg::UNMAPPED_READ;
    end else if (bus.rd) begin
      RDATA_O <= rdata_next;
    end else begin
      RDATA_O <= fsol_pkg::UNMAPPED_READ;
    end
  end
endmodule

// ### dv/fsol_top_assertions.sv
// checker of the security option loader ports
module fsol_top_checker (
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic [15:0] ADDR_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [7:0] RDATA_O,
  input wire logic SECURE_CODE_I,
  input wire logic DEBUG_ACCESS_I,
  input wire logic [15:0] NV_ADDR_O,
  input wire logic NV_RD_O,
  input wire logic [7:0] FLASH_CMD_I,
  input wire logic FLASH_CMD_DONE_I,
  input wire logic FLASH_BLANK_I,
  input wire logic LOAD_BUSY_O,
  input wire logic SECURE_O,
  input wire logic KEY_UNLOCKED_O
);
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  property p_load_seq;
    $rose(NV_RD_O) |-> NV_ADDR_O == 16'hffb0 ##9 NV_ADDR_O == 16'hffbf ##1 !NV_RD_O;
  endproperty
  a_load_seq: assert property (p_load_seq) else $error("load order off");
  property p_rd_only_load;
    NV_RD_O |-> LOAD_BUSY_O;
  endproperty
  a_rd_only_load: assert property (p_rd_only_load) else $error("late load read");
  property p_secure_load;
    LOAD_BUSY_O |-> SECURE_O;
  endproperty
  a_secure_load: assert property (p_secure_load) else $error("open during load");
  property p_rdata_idle;
    !RD_I |=> RDATA_O == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data stuck");
  property p_key_origin;
    $rose(KEY_UNLOCKED_O) |-> $past(WR_I, 2) && $past(SECURE_CODE_I, 2)
      && !$past(DEBUG_ACCESS_I, 2) && $past(ADDR_I[15:3], 2) == 13'h1ff6;
  endproperty
  a_key_origin: assert property (p_key_origin) else $error("bad unlock origin");
  property p_key_hold;
    KEY_UNLOCKED_O |=> KEY_UNLOCKED_O;
  endproperty
  a_key_hold: assert property (p_key_hold) else $error("unlock lost");
  property p_key_open;
    KEY_UNLOCKED_O |-> !SECURE_O;
  endproperty
  a_key_open: assert property (p_key_open) else $error("unlocked but secure");
  // erase path only; load end and key unlock excluded
  property p_erase_open;
    $fell(SECURE_O) && !KEY_UNLOCKED_O && !$past(LOAD_BUSY_O) && !$past(LOAD_BUSY_O, 2)
      |-> $past(FLASH_CMD_DONE_I) && $past(FLASH_BLANK_I) && $past(FLASH_CMD_I) == 8'h05;
  endproperty
  a_erase_open: assert property (p_erase_open) else $error("bad erase clear");
endmodule
bind fsol_top fsol_top_checker fsol_top_checker_i (.SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I),
  .ADDR_I(ADDR_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .SECURE_CODE_I(SECURE_CODE_I),
  .DEBUG_ACCESS_I(DEBUG_ACCESS_I), .NV_ADDR_O(NV_ADDR_O), .NV_RD_O(NV_RD_O),
  .FLASH_CMD_I(FLASH_CMD_I), .FLASH_CMD_DONE_I(FLASH_CMD_DONE_I), .FLASH_BLANK_I(FLASH_BLANK_I),
  .LOAD_BUSY_O(LOAD_BUSY_O), .SECURE_O(SECURE_O), .KEY_UNLOCKED_O(KEY_UNLOCKED_O));

// ### dv/test_fsol_top.sv
// testbench of the security option loader
module test_fsol_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // signals and stored area
  // ****************************************************************
  logic clk, rst, wr, rd, sc, dbg, nv_rd, fdone, fblank, busy, secure, unl, vrd;
  logic [15:0] addr, nv_addr;
  logic [7:0] wdata, rdata, nv_rdata, fcode, prot, nv_opt, nv_prot;
  int num_errors = 0;
  int compares = 0;
  int cyc = 0;
  fsol_top fsol_top_i (.SYS_CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .SECURE_CODE_I(sc), .DEBUG_ACCESS_I(dbg),
    .NV_ADDR_O(nv_addr), .NV_RD_O(nv_rd), .NV_RDATA_I(nv_rdata), .FLASH_CMD_I(fcode),
    .FLASH_CMD_DONE_I(fdone), .FLASH_BLANK_I(fblank), .LOAD_BUSY_O(busy), .SECURE_O(secure),
    .KEY_UNLOCKED_O(unl), .PROTECTION_O(prot), .VECTOR_REDIRECT_DISABLE_O(vrd));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // stored area answers one cycle after the address; odd places give junk
  always @(posedge clk) begin
    if (nv_addr[15:3] == 13'h1ff6) nv_rdata <= 8'ha0 | {5'h00, nv_addr[2:0]};
    else if (nv_addr == 16'hffbd) nv_rdata <= nv_prot;
    else if (nv_addr == 16'hffbf) nv_rdata <= nv_opt;
    else nv_rdata <= ~nv_addr[7:0];
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      end_of_test();
    end
  end
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic keys(input logic bad);
    for (int i = 0; i < 8; i++) wr_reg(16'hffb0 + 16'(i), 8'ha0 | 8'(i) ^ {7'h00, bad});
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic fcmd(input logic [7:0] c, input logic b);
    @(posedge clk);
    fcode <= c;
    fblank <= b;
    fdone <= 1'b1;
    @(posedge clk);
    fdone <= 1'b0;
  endtask
  task automatic boot(input logic [7:0] o);
    nv_opt = o;
    @(posedge clk);
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (14) @(posedge clk);
    #1;
    chk({7'h00, busy}, 8'h00);
  endtask
  task automatic end_of_test();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {rst, wr, rd, sc, dbg, fdone, fblank} = 7'h40;
    {addr, wdata, fcode} = 32'h0;
    nv_prot = 8'h5a;
    boot(8'hc1);
    chk({7'h00, secure}, 8'h01);
    chk(prot, 8'h5a);
    chk({7'h00, vrd}, 8'h01);
    rd_reg(16'h1821, 8'hc1 & fsol_pkg::OPTION_RW_MASK);
    rd_reg(16'h1824, 8'h5a);
    rd_reg(16'hffbf, 8'hc1);
    rd_reg(16'hffbd, 8'h5a);
    rd_reg(16'hffb3, 8'h00);
    rd_reg(16'h1822, 8'h00);
    wr_reg(16'h1824, 8'h33);
    rd_reg(16'h1824, 8'h33);
    @(posedge clk);
    dbg <= 1'b1;
    sc <= 1'b1;
    wr_reg(16'h1823, 8'h20);
    rd_reg(16'h1823, 8'h00);
    @(posedge clk);
    dbg <= 1'b0;
    sc <= 1'b0;
    wr_reg(16'h1823, 8'h20);
    rd_reg(16'h1823, 8'h00);
    @(posedge clk);
    sc <= 1'b1;
    wr_reg(16'h1823, 8'h20);
    rd_reg(16'h1823, 8'h20);
    // armed, yet key bytes from the debug side never reach the compare
    @(posedge clk);
    dbg <= 1'b1;
    keys(1'b0);
    chk({7'h00, unl}, 8'h00);
    @(posedge clk);
    dbg <= 1'b0;
    keys(1'b1);
    chk({7'h00, unl}, 8'h00);
    // disarm drops the bad bytes before the good attempt
    wr_reg(16'h1823, 8'h00);
    wr_reg(16'h1823, 8'h20);
    keys(1'b0);
    chk({7'h00, unl}, 8'h01);
    chk({7'h00, secure}, 8'h00);
    rd_reg(16'h1828, 8'h02);
    boot(8'h01);
    wr_reg(16'h1823, 8'h20);
    rd_reg(16'h1823, 8'h00);
    keys(1'b0);
    chk({7'h00, unl}, 8'h00);
    fcmd(fsol_pkg::CMD_MASS_ERASE, 1'b0);
    fcmd(8'h20, 1'b0);
    fcmd(fsol_pkg::CMD_BLANK_CHECK, 1'b1);
    fcmd(fsol_pkg::CMD_MASS_ERASE, 1'b0);
    fcmd(fsol_pkg::CMD_BLANK_CHECK, 1'b0);
    @(posedge clk);
    #1;
    chk({7'h00, secure}, 8'h01);
    fcmd(fsol_pkg::CMD_MASS_ERASE, 1'b0);
    fcmd(fsol_pkg::CMD_BLANK_CHECK, 1'b1);
    @(posedge clk);
    #1;
    chk({7'h00, secure}, 8'h00);
    rd_reg(16'h1828, 8'h04);
    boot(8'h02);
    chk({7'h00, secure}, 8'h00);
    chk({7'h00, vrd}, 8'h00);
    end_of_test();
  end
endmodule
